// ===== logic/cfdcb_top.sv
// Configuration bank for filter cutoffs, bypass, probe select and write drivers.
// Assumes serial clock, enable and data are synchronous to clk_i; the host
// shifts a 16-bit frame, LSB first: read/write bit (write = 0), 7 address bits,
// 8 data bits, and the write takes effect when the enable falls.
// Behaviour
// - Servo high-pass codes: servo 1 in bits 7-4, servo 0 in bits 3-0.
// - Each data low-pass register: bit 7 doubles range, bits 6-0 cutoff code.
// - Each servo low-pass register: bit 7 doubles range, bits 6-0 cutoff code.
// - Six bypass bits, bit n for filter n+1; bits 7-6 read zero.
// - Probe select codes: 00 off, 01 preamp, 10 gain stage, 11 filter.
// - First probe register: bits 5-4, 3-2, 1-0 for data pairs 2, 1, 0.
// - Second probe register: servo bottom, servo top, data pair 3.
// - Driver bit 7 set toggles on write-data rising edge, else follows level.
// - Driver bits 6-0 hold the write current code, 0 to 127.
module cfdcb_top
   import cfdcb_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // Serial port
   input  wire logic         ser_clk_i,
   input  wire logic         ser_en_i,
   input  wire logic         ser_data_i,
   output logic              ser_data_o,
   output logic              ser_data_oe_o,
   // Write data inputs, one per driver
   input  wire logic [3:0]   write_data_i,
   // Filter controls
   output logic [3:0]        servo0_highpass_code_o,
   output logic [3:0]        servo1_highpass_code_o,
   output logic [3:0]        data_range_double_o,
   output logic [27:0]       data_lowpass_code_o,
   output logic [1:0]        servo_range_double_o,
   output logic [13:0]       servo_lowpass_code_o,
   output logic [5:0]        filter_unity_gain_o,
   // Probe selects
   output cfdcb_pkg::cfdcb_probe_t probe_select_o [6],
   // Write drivers
   output logic [3:0]        driver_toggle_select_o,
   output logic [27:0]       driver_current_code_o,
   output logic [3:0]        driver_state_o
);
   import cfdcb_pkg::*;

   localparam int IDX_W = 4;

   cfdcb_sp_state_t  sp_state_q;
   logic [4:0]       bit_cnt_q;
   logic [15:0]      shift_q;
   logic             ser_clk_q;
   logic             wr_en_q;
   logic [IDX_W-1:0] wr_idx_q;
   logic [7:0]       wr_data_q;
   logic [7:0]       wr_mask_q;
   logic [IDX_W-1:0] rd_idx_q;
   logic [7:0]       rd_data;
   logic [8*NUM_CFG-1:0] all_regs;
   logic [7:0]       rd_shift_q;
   logic [3:0]       wdata_q;
   logic [7:0]       test_q [11];

   // Maps a printed register index to a slot in the memory; 15 means unmapped.
   function automatic logic [IDX_W-1:0] slot_of(input logic [6:0] idx);
      logic [IDX_W-1:0] s;
      s = 4'hF;
      if (idx >= IDX_SERVO_HP && idx <= IDX_SERVO1_LP) begin
         s = IDX_W'(idx - IDX_SERVO_HP);
      end else if (idx >= IDX_BYPASS && idx <= IDX_DRV0 + 7'(NUM_DRV - 1)) begin
         s = IDX_W'(idx - IDX_BYPASS + 7'd7);
      end
      return s;
   endfunction

   // Bits 7-6 of bypass and probe registers are unused and stay zero.
   function automatic logic [7:0] mask_of(input logic [IDX_W-1:0] s);
      return (s >= 4'd7 && s <= 4'd9) ? MASK_SIX : MASK_FULL;
   endfunction

   wire ser_rise = ser_clk_i && !ser_clk_q;
   wire [6:0] fr_addr = shift_q[7:1];
   wire       fr_read = shift_q[0];
   // After eight bits the read flag sits at bit 8; bit 0 still holds the previous frame.
   wire       hdr_read = shift_q[8];

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ser_clk_q <= 1'b0;
      end else begin
         ser_clk_q <= ser_clk_i;
      end
   end

   // Frame shifter. Bits arrive LSB first, so each new bit enters at the top.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sp_state_q <= SP_IDLE;
         bit_cnt_q  <= '0;
         shift_q    <= '0;
      end else begin
         case (sp_state_q)
            SP_IDLE: begin
               if (ser_en_i) begin
                  sp_state_q <= SP_SHIFT;
                  bit_cnt_q  <= '0;
               end
            end
            SP_SHIFT: begin
               if (!ser_en_i) begin
                  sp_state_q <= SP_DONE;
               end else if (ser_rise && bit_cnt_q < 5'(FRAME_BITS)) begin
                  shift_q   <= {ser_data_i, shift_q[15:1]};
                  bit_cnt_q <= bit_cnt_q + 5'd1;
               end
            end
            SP_DONE: sp_state_q <= SP_IDLE;
            default: sp_state_q <= SP_IDLE;
         endcase
      end
   end

   // A complete write frame commits on the falling enable. The test range is
   // kept apart so a stray write cannot disturb the live controls.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_en_q   <= 1'b0;
         wr_idx_q  <= '0;
         wr_data_q <= CFG_RESET;
         wr_mask_q <= MASK_FULL;
      end else begin
         wr_en_q <= sp_state_q == SP_DONE && bit_cnt_q == 5'(FRAME_BITS) && !fr_read
                    && slot_of(fr_addr) != 4'hF;
         wr_idx_q  <= slot_of(fr_addr);
         wr_data_q <= shift_q[15:8];
         wr_mask_q <= mask_of(slot_of(fr_addr));
      end
   end

   // Factory test registers keep their contents; the host is expected not to write them.
   genvar t;
   generate
      for (t = 0; t < 11; t++) begin : g_test
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               test_q[t] <= CFG_RESET;
            end
         end
      end
   endgenerate

   cfdcb_regmem #(
      .DEPTH (NUM_CFG),
      .WIDTH (DATA_W),
      .IDX_W (IDX_W)
   ) u_mem (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .wr_en_i   (wr_en_q),
      .wr_idx_i  (wr_idx_q),
      .wr_data_i (wr_data_q),
      .wr_mask_i (wr_mask_q),
      .rd_idx_i  (rd_idx_q),
      .rd_data_o (rd_data),
      .all_o     (all_regs)
   );

   // Read frames: after the 8 header bits the device drives data LSB first.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_idx_q      <= '0;
         rd_shift_q    <= '0;
         ser_data_o    <= 1'b0;
         ser_data_oe_o <= 1'b0;
      end else begin
         if (sp_state_q == SP_SHIFT && bit_cnt_q == 5'd8 && hdr_read) begin
            rd_idx_q <= slot_of(shift_q[15:9]);
         end
         if (sp_state_q == SP_SHIFT && bit_cnt_q == 5'd8 && hdr_read && !ser_clk_i) begin
            ser_data_oe_o <= 1'b1;
            ser_data_o    <= rd_data[0];
            rd_shift_q    <= {1'b0, rd_data[7:1]};
         end else if (ser_data_oe_o && ser_rise) begin
            ser_data_o <= rd_shift_q[0];
            rd_shift_q <= {1'b0, rd_shift_q[7:1]};
         end
         if (sp_state_q != SP_SHIFT || !ser_en_i) begin
            ser_data_oe_o <= 1'b0;
         end
      end
   end

   // Decoded controls, registered so every output comes from a flip-flop.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         servo0_highpass_code_o <= '0;
         servo1_highpass_code_o <= '0;
         data_range_double_o    <= '0;
         data_lowpass_code_o    <= '0;
         servo_range_double_o   <= '0;
         servo_lowpass_code_o   <= '0;
         filter_unity_gain_o    <= '0;
         driver_toggle_select_o <= '0;
         driver_current_code_o  <= '0;
      end else begin
         servo1_highpass_code_o <= all_regs[HP_SERVO1_LSB +: 4];
         servo0_highpass_code_o <= all_regs[HP_SERVO0_LSB +: 4];
         for (int i = 0; i < 4; i++) begin
            data_range_double_o[i]      <= all_regs[8*(1+i) + LP_RANGE_BIT];
            data_lowpass_code_o[7*i +: 7] <= all_regs[8*(1+i) +: 7];
            driver_toggle_select_o[i]   <= all_regs[8*(10+i) + DRV_TOGGLE_BIT];
            driver_current_code_o[7*i +: 7] <= all_regs[8*(10+i) +: 7];
         end
         for (int i = 0; i < 2; i++) begin
            servo_range_double_o[i]        <= all_regs[8*(5+i) + LP_RANGE_BIT];
            servo_lowpass_code_o[7*i +: 7] <= all_regs[8*(5+i) +: 7];
         end
         filter_unity_gain_o <= all_regs[8*7 +: 6];
      end
   end

   // Probe selects: slots 0-2 from the first register, 3-5 from the second.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 6; i++) begin
            probe_select_o[i] <= PROBE_HIZ;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            probe_select_o[i]   <= cfdcb_probe_t'(all_regs[8*8 + 2*i +: 2]);
            probe_select_o[i+3] <= cfdcb_probe_t'(all_regs[8*9 + 2*i +: 2]);
         end
      end
   end

   // Driver state: toggle on a rising write-data edge, or follow the level.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wdata_q        <= '0;
         driver_state_o <= '0;
      end else begin
         wdata_q <= write_data_i;
         for (int i = 0; i < NUM_DRV; i++) begin
            if (driver_toggle_select_o[i]) begin
               if (write_data_i[i] && !wdata_q[i]) begin
                  driver_state_o[i] <= !driver_state_o[i];
               end
            end else begin
               driver_state_o[i] <= write_data_i[i];
            end
         end
      end
   end

   // Checks.
   servo_hp_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      servo1_highpass_code_o == $past(all_regs[7:4]))
      else $error("servo high-pass code mismatch");
   data_lp_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      {data_range_double_o[0], data_lowpass_code_o[6:0]} == $past(all_regs[15:8]))
      else $error("data low-pass mapping wrong");
   servo_lp_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      {servo_range_double_o[1], servo_lowpass_code_o[13:7]} == $past(all_regs[55:48]))
      else $error("servo low-pass mapping wrong");
   bypass_top_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      all_regs[63:62] == 2'b00)
      else $error("bypass unused bits set");
   probe_a_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      probe_select_o[2] == cfdcb_probe_t'($past(all_regs[69:68])))
      else $error("probe pair 2 select wrong");
   probe_b_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      probe_select_o[5] == cfdcb_probe_t'($past(all_regs[77:76])))
      else $error("servo bottom probe select wrong");
   drv_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !driver_toggle_select_o[0] |=> driver_state_o[0] == $past(write_data_i[0]))
      else $error("driver not following level");
   drv_toggle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      driver_toggle_select_o[0] && $rose(write_data_i[0]) |=>
      driver_state_o[0] != $past(driver_state_o[0]))
      else $error("driver did not toggle");
   drv_code_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      driver_current_code_o[27:21] == $past(all_regs[110:104]))
      else $error("driver current code wrong");
   hold_value_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !wr_en_q |=> $stable(all_regs))
      else $error("register changed without write");
   probe_tie_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 probe_select_o[0] == cfdcb_probe_t'($past(all_regs[65:64])))
      else $error("probe code not passed through");

   write_seen_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_en_q);
   read_seen_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) ser_data_oe_o);
   toggle_seen_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      driver_toggle_select_o[0] && $rose(write_data_i[0]));
endmodule

// ===== inc/cfdcb_pkg.sv
// Package for the channel filter and driver configuration bank.
// Assumes a host that reaches the bank through a three-wire serial port.
package cfdcb_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int FRAME_BITS = 16;
   // Register indices, as printed.
   localparam logic [6:0] IDX_SERVO_HP = 7'h1B;
   localparam logic [6:0] IDX_DATA0_LP = 7'h1C;
   localparam logic [6:0] IDX_DATA1_LP = 7'h1D;
   localparam logic [6:0] IDX_DATA2_LP = 7'h1E;
   localparam logic [6:0] IDX_DATA3_LP = 7'h1F;
   localparam logic [6:0] IDX_SERVO0_LP = 7'h20;
   localparam logic [6:0] IDX_SERVO1_LP = 7'h21;
   localparam logic [6:0] IDX_BYPASS = 7'h2E;
   localparam logic [6:0] IDX_PROBE_A = 7'h2F;
   localparam logic [6:0] IDX_PROBE_B = 7'h30;
   localparam logic [6:0] IDX_DRV0 = 7'h31;
   localparam logic [6:0] IDX_TEST_LO = 7'h35;
   localparam logic [6:0] IDX_TEST_HI = 7'h3F;
   localparam int NUM_CFG = 14;
   localparam int NUM_DRV = 4;
   // Field positions.
   localparam int HP_SERVO1_LSB = 4;
   localparam int HP_SERVO0_LSB = 0;
   localparam int LP_RANGE_BIT = 7;
   localparam int DRV_TOGGLE_BIT = 7;
   localparam int PROBE_SLOT2_LSB = 4;
   localparam int PROBE_SLOT1_LSB = 2;
   localparam int PROBE_SLOT0_LSB = 0;
   // Reset values and writable masks.
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] MASK_SIX = 8'h3F;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   typedef enum logic [1:0] {
      PROBE_HIZ    = 2'b00,
      PROBE_PREAMP = 2'b01,
      PROBE_GAIN   = 2'b10,
      PROBE_FILTER = 2'b11
   } cfdcb_probe_t;
   typedef enum logic [1:0] {
      SP_IDLE  = 2'b00,
      SP_SHIFT = 2'b01,
      SP_DONE  = 2'b10
   } cfdcb_sp_state_t;
endpackage

// ===== logic/cfdcb_regmem.sv
// Small register memory holding the configuration bytes.
// Assumes one write port and one read port in the same clock domain.
module cfdcb_regmem #(
   parameter int DEPTH  = 14,
   parameter int WIDTH  = 8,
   parameter int IDX_W  = 4
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Write port
   input  wire logic             wr_en_i,
   input  wire logic [IDX_W-1:0] wr_idx_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic [WIDTH-1:0] wr_mask_i,
   // Read port
   input  wire logic [IDX_W-1:0] rd_idx_i,
   output logic      [WIDTH-1:0] rd_data_o,
   // Whole contents
   output logic      [WIDTH*DEPTH-1:0] all_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_word
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               mem_q[g] <= '0;
            end else if (wr_en_i && wr_idx_i == IDX_W'(g)) begin
               mem_q[g] <= wr_data_i & wr_mask_i;
            end
         end
         assign all_o[g*WIDTH +: WIDTH] = mem_q[g];
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= '0;
      end else if (int'(rd_idx_i) < DEPTH) begin
         rd_data_o <= mem_q[rd_idx_i];
      end else begin
         rd_data_o <= '0;
      end
   end
endmodule

// ===== bench/cfdcb_host_model.sv
// Host controller model for the three-wire serial port of the configuration bank.
// Assumes the bank samples the serial lines on clk_i and drives the shared data line on a read.
module cfdcb_host_model
   import cfdcb_pkg::*;
(
   // Clock
   input  wire logic clk_i,
   // Device side of the data line
   input  wire logic dev_data_i,
   input  wire logic dev_oe_i,
   // Serial port
   output logic      ser_clk_o,
   output logic      ser_en_o,
   output logic      ser_line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic host_drv;
   logic host_bit;
   logic float_q;
   initial begin
      ser_clk_o = 1'b0;
      ser_en_o = 1'b0;
      host_drv = 1'b1;
      host_bit = 1'b0;
      float_q = 1'b0;
   end
   // A released line shows a pattern that changes every cycle, so no stale bit reads as valid.
   always @(posedge clk_i) begin
      float_q <= ~float_q;
   end
   assign ser_line_o = dev_oe_i ? dev_data_i : (host_drv ? host_bit : float_q);
   task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d,
                        input int n, output logic [7:0] q);
      logic [15:0] f;
      int i;
      f = {d, a, rw};
      q = 8'h00;
      if (!rw && a >= IDX_TEST_LO && a <= IDX_TEST_HI) return;
      @(posedge clk_i);
      #10 ser_en_o = 1'b1;
      for (i = 0; i < n; i++) begin
         @(posedge clk_i);
         #10 host_drv = !(rw && i >= 8);
         host_bit = f[i];
         @(posedge clk_i);
         #10;
         if (rw && i >= 8) q[i-8] = ser_line_o;
         ser_clk_o = 1'b1;
         repeat (2) @(posedge clk_i);
         #10 ser_clk_o = 1'b0;
      end
      @(posedge clk_i);
      #10 ser_en_o = 1'b0;
      host_drv = 1'b1;
      repeat (5) @(posedge clk_i);
      // Returning off the edge keeps the caller's checks clear of the edge that moves outputs.
      #10;
   endtask
endmodule

// ===== bench/channel_filter_driver_config_bank_tb_top.sv
// Self-checking bench for the configuration bank, compared with a register model.
// Assumes the host model frames every access and waits out the commit latency.
module channel_filter_driver_config_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cfdcb_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] write_data_i = 4'h0;
   wire logic ser_clk, ser_en, ser_line;
   logic ser_data_o, ser_data_oe_o;
   logic [3:0] servo0_hp, servo1_hp, data_rd, tog, state;
   logic [27:0] data_lp, cur;
   logic [1:0] servo_rd;
   logic [13:0] servo_lp;
   logic [5:0] unity;
   cfdcb_probe_t probe_select_o [6];
   int error_cnt = 0;
   int check_count = 0;
   int seed = 70;
   logic [7:0] m [0:127];
   logic [3:0] st;
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   cfdcb_host_model host_u (.clk_i(clk_i), .dev_data_i(ser_data_o), .dev_oe_i(ser_data_oe_o),
      .ser_clk_o(ser_clk), .ser_en_o(ser_en), .ser_line_o(ser_line));
   cfdcb_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ser_clk_i(ser_clk),
      .ser_en_i(ser_en), .ser_data_i(ser_line), .ser_data_o(ser_data_o),
      .ser_data_oe_o(ser_data_oe_o), .write_data_i(write_data_i),
      .servo0_highpass_code_o(servo0_hp), .servo1_highpass_code_o(servo1_hp),
      .data_range_double_o(data_rd), .data_lowpass_code_o(data_lp),
      .servo_range_double_o(servo_rd), .servo_lowpass_code_o(servo_lp),
      .filter_unity_gain_o(unity), .probe_select_o(probe_select_o),
      .driver_toggle_select_o(tog), .driver_current_code_o(cur), .driver_state_o(state));
   task automatic chk(input logic [127:0] g, input logic [127:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_all;
      logic [27:0] dlp, ecur;
      logic [13:0] slp;
      logic [3:0] drd, etog;
      logic [1:0] srd;
      logic [11:0] prb, prg;
      int i;
      for (i = 0; i < 4; i++) begin
         dlp[7*i+:7] = m[IDX_DATA0_LP+i][6:0];
         drd[i] = m[IDX_DATA0_LP+i][LP_RANGE_BIT];
         ecur[7*i+:7] = m[IDX_DRV0+i][6:0];
         etog[i] = m[IDX_DRV0+i][DRV_TOGGLE_BIT];
      end
      for (i = 0; i < 2; i++) begin
         slp[7*i+:7] = m[IDX_SERVO0_LP+i][6:0];
         srd[i] = m[IDX_SERVO0_LP+i][LP_RANGE_BIT];
      end
      for (i = 0; i < 3; i++) begin
         prb[2*i+:2] = m[IDX_PROBE_A][2*i+:2];
         prb[2*i+6+:2] = m[IDX_PROBE_B][2*i+:2];
      end
      for (i = 0; i < 6; i++) prg[2*i+:2] = probe_select_o[i];
      chk({servo1_hp, servo0_hp}, m[IDX_SERVO_HP]);
      chk({data_rd, data_lp}, {drd, dlp});
      chk({servo_rd, servo_lp}, {srd, slp});
      chk(unity, m[IDX_BYPASS][5:0]);
      chk(prg, prb);
      chk({tog, cur, state}, {etog, ecur, st});
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      int i;
      host_u.frame(1'b0, a, d, 16, q);
      if ((a >= IDX_SERVO_HP && a <= IDX_SERVO1_LP) || (a >= IDX_BYPASS && a < IDX_TEST_LO))
         m[a] = (a >= IDX_BYPASS && a < IDX_DRV0) ? (d & MASK_SIX) : d;
      for (i = 0; i < 4; i++) if (!m[IDX_DRV0+i][7]) st[i] = write_data_i[i];
      chk_all;
   endtask
   task automatic rd(input logic [6:0] a);
      logic [7:0] q;
      host_u.frame(1'b1, a, 8'h00, 16, q);
      chk(q, m[a]);
      chk_all;
   endtask
   task automatic drive_wd(input logic [3:0] v);
      int i;
      @(posedge clk_i);
      #10;
      for (i = 0; i < 4; i++) begin
         if (m[IDX_DRV0+i][7]) begin
            if (v[i] && !write_data_i[i]) st[i] = ~st[i];
         end else st[i] = v[i];
      end
      write_data_i = v;
      repeat (3) @(posedge clk_i);
      #10 chk_all;
   endtask
   function automatic logic [7:0] lp_val();
      return {1'($random(seed)), 7'(13 + $unsigned($random(seed)) % 115)};
   endfunction
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_i);
      error_cnt++;
      $display("watchdog expired at %0t", $time);
      end_of_test;
   end
   initial begin
      int i, a;
      logic [7:0] d, q;
      for (i = 0; i < 128; i++) m[i] = CFG_RESET;
      st = 4'h0;
      repeat (8) @(posedge clk_i);
      #10 sys_rst_i = 1'b0;
      @(posedge clk_i);
      #10 chk_all;
      for (i = 0; i < 4; i++) begin
         wr(IDX_PROBE_A, 8'hC0 | 8'(i * 21));
         wr(IDX_PROBE_B, 8'h80 | 8'(i * 21));
      end
      wr(IDX_BYPASS, MASK_FULL);
      for (i = 0; i < 30; i++) begin
         a = IDX_SERVO_HP + $unsigned($random(seed)) % 22;
         d = 8'($random(seed));
         if (a >= IDX_DATA0_LP && a <= IDX_SERVO1_LP) d = lp_val();
         wr(7'(a), d);
      end
      for (i = 0; i < 10; i++) rd(7'(i < 7 ? IDX_SERVO_HP + i : IDX_BYPASS + i - 7));
      // A frame one bit short must leave the register alone.
      host_u.frame(1'b0, IDX_SERVO_HP, ~m[IDX_SERVO_HP], 15, q);
      chk_all;
      for (i = 0; i < 4; i++) begin
         d = {1'(i % 2 == 0), 7'($random(seed))};
         if (i < 2) d[6:0] = (i == 0) ? 7'h7F : 7'h00;
         wr(7'(IDX_DRV0 + i), d);
      end
      repeat (6) drive_wd(4'($random(seed)));
      for (i = 0; i < 4; i++) wr(7'(IDX_DRV0 + i), {1'b0, 7'($random(seed))});
      repeat (4) drive_wd(4'($random(seed)));
      drive_wd(4'h0);
      @(posedge clk_i);
      #10 sys_rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #10 sys_rst_i = 1'b0;
      for (i = 0; i < 128; i++) m[i] = CFG_RESET;
      st = 4'h0;
      @(posedge clk_i);
      #10 chk_all;
      wr(IDX_DATA3_LP, 8'h8D);
      end_of_test;
   end
endmodule
